// ### design/glrt_listener_rx.sv
// Listener receive termination logic with APB registers, DMA port and interrupt
`timescale 1ns/10ps
`include "glrt_params.svh"
// Functional notes
// - String receive stops when a further kept character exceeds the buffer length.
// - String receive stops when the selected terminator character arrives.
// - Any byte arriving with EOI asserted stops reception.
// - String receive drops carriage returns and the terminator character.
// - Terminator numbers 0..3 default to LF, CR, comma, semicolon.
// - Each terminator character is reprogrammable by software.
// - Status bit 3 set on timeout during transfer, else zero.
// - String status bit 2 set when a further kept character without EOI arrives at a full buffer.
// - Status bit 1 set when receive requested while not addressed to listen.
// - Completion reports the exact number of bytes received and kept.
// - String receive without explicit terminator number uses terminator 0.
// - A string buffer length is limited to 64 KBytes.
// - Array control byte: bit 2 enables terminator, bits 1:0 select, rest ignored.
// - Array receive data may be drained by DMA instead of register reads.
// - Array receive ends once the maximum byte count is received.
// - Array status bit 5 set on EOI or terminator end, else clear.
module glrt_listener_rx #(
  parameter int unsigned TMO_CYCLES = `GLRT_TIMEOUT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Bus acceptor side pins
  input wire logic bus_dav,
  input wire logic bus_eoi,
  input wire logic [7:0] bus_data,
  input wire logic listen_addressed,
  output logic bus_accept,
  // DMA drain
  output logic dma_req,
  output logic [7:0] dma_data,
  input wire logic dma_ack,
  // Interrupt
  output logic irq
);
  // ==========================================================
  // Reset synchroniser
  logic rst_meta_ff;
  logic rst_sync_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  wire rst_sync_n = rst_sync_ff;

  // ==========================================================
  // Pin synchronisers; first stage feeds only the second
  logic [10:0] pin_meta_ff;
  logic [10:0] pin_sync_ff;
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_meta_ff <= 11'h000;
      pin_sync_ff <= 11'h000;
    end else begin
      pin_meta_ff <= {listen_addressed, bus_eoi, bus_dav, bus_data};
      pin_sync_ff <= pin_meta_ff;
    end
  end
  wire [7:0] rx_byte = pin_sync_ff[7:0];
  wire rx_dav = pin_sync_ff[8];
  wire rx_eoi = pin_sync_ff[9];
  wire is_listener = pin_sync_ff[10];

  // Picks one character out of the packed terminator table
  function automatic logic [7:0] term_of(input logic [31:0] table_w, input logic [1:0] sel);
    term_of = table_w[8*sel +: 8];
  endfunction

  // ==========================================================
  // State and registers
  glrt_pkg::glrt_state_type state_ff, nxt_state;
  logic end_seen_ff;
  glrt_pkg::glrt_mode_type mode_ff;
  logic [16:0] len_ff;
  logic [31:0] terms_ff;
  logic [7:0] status_ff;
  logic [16:0] count_ff;
  logic [1:0] tsel_ff;
  logic term_en_ff;
  logic dma_en_ff;
  logic [7:0] hold_ff;
  logic hold_v_ff;
  logic [1:0] istat_ff;
  logic [1:0] imask_ff;
  logic [31:0] tmo_cnt_ff;

  // ==========================================================
  // APB decode; zero wait states, unmapped offsets answer with an error
  wire apb_acc = psel & penable;
  wire apb_wr = apb_acc & pwrite;
  wire apb_rd = apb_acc & ~pwrite;
  wire hit_ctrl = (paddr == `GLRT_OFS_CTRL);
  wire hit_len = (paddr == `GLRT_OFS_LEN);
  wire hit_terms = (paddr == `GLRT_OFS_TERMS);
  wire hit_status = (paddr == `GLRT_OFS_STATUS);
  wire hit_count = (paddr == `GLRT_OFS_COUNT);
  wire hit_data = (paddr == `GLRT_OFS_DATA);
  wire hit_istat = (paddr == `GLRT_OFS_ISTAT);
  wire hit_imask = (paddr == `GLRT_OFS_IMASK);
  wire hit_any = hit_ctrl | hit_len | hit_terms | hit_status | hit_count | hit_data |
                 hit_istat | hit_imask;
  assign pready = 1'b1;
  assign pslverr = apb_acc & ~hit_any;

  // Read mux over flops; unassigned bits are zero
  logic busy;
  assign busy = (state_ff != glrt_pkg::GLRT_IDLE);
  assign prdata = hit_ctrl ? {24'h00_0000, dma_en_ff, term_en_ff, 3'b000, tsel_ff, busy} :
                  hit_len ? {15'h0000, len_ff} :
                  hit_terms ? terms_ff :
                  hit_status ? {24'h00_0000, status_ff} :
                  hit_count ? {15'h0000, count_ff} :
                  hit_data ? {23'h00_0000, hold_v_ff, hold_ff} :
                  hit_istat ? {30'h0000_0000, istat_ff} :
                  hit_imask ? {30'h0000_0000, imask_ff} : 32'h0000_0000;

  // ==========================================================
  // Start requests, ignored while a receive is running
  wire start_str = apb_wr & hit_ctrl & pwdata[`GLRT_CTL_START_STR] & ~busy;
  wire start_arr = apb_wr & hit_ctrl & pwdata[`GLRT_CTL_START_ARR] & ~busy &
                   ~pwdata[`GLRT_CTL_START_STR];
  wire start_any = start_str | start_arr;
  wire [7:0] actl = pwdata[`GLRT_CTL_ACTL_LSB +: 8];
  wire [1:0] str_tsel = pwdata[`GLRT_CTL_USE_TNUM] ? pwdata[`GLRT_CTL_TNUM_LSB +: 2] :
                        2'b00;
  wire arr_ctl = pwdata[`GLRT_CTL_ACTL_VALID];
  wire [1:0] arr_tsel = arr_ctl ? actl[1:0] : 2'b00;
  wire arr_ten = arr_ctl & actl[`GLRT_ACTL_TERM_EN];
  wire start_nl = start_any & ~is_listener;

  // ==========================================================
  // Byte classification while waiting
  wire in_wait = (state_ff == glrt_pkg::GLRT_WAIT);
  wire take = in_wait & rx_dav & ~hold_v_ff;
  wire is_array = (mode_ff == glrt_pkg::GLRT_MODE_ARRAY);
  wire [7:0] term_char = term_of(terms_ff, tsel_ff);
  wire is_cr = (rx_byte == `GLRT_CR_CHAR);
  wire is_term = term_en_ff & (rx_byte == term_char);
  wire str_drop = is_cr | is_term;
  wire str_ovf = ~str_drop & (count_ff == len_ff);
  wire [16:0] count_inc = count_ff + 17'h0_0001;
  wire arr_full = (count_inc >= len_ff);
  wire keep = take & (is_array | (~str_drop & ~str_ovf));
  wire end_eot = rx_eoi | is_term;
  wire end_rx = take & (end_eot | (is_array ? arr_full : str_ovf));
  wire tmo_hit = in_wait & ~take & (tmo_cnt_ff >= TMO_CYCLES - 1);
  wire done = end_rx | tmo_hit | start_nl;

  // ==========================================================
  // Sequencer: wait for a byte, hold accept until the talker drops valid
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      glrt_pkg::GLRT_IDLE: begin
        if (start_any & is_listener) begin
          nxt_state = glrt_pkg::GLRT_WAIT;
        end
      end
      glrt_pkg::GLRT_WAIT: begin
        if (tmo_hit) begin
          nxt_state = glrt_pkg::GLRT_IDLE;
        end else if (take) begin
          nxt_state = glrt_pkg::GLRT_ACK;
        end
      end
      glrt_pkg::GLRT_ACK: begin
        if (!rx_dav) begin
          nxt_state = status_ff[`GLRT_ST_EOT] | end_seen_ff ? glrt_pkg::GLRT_IDLE :
                      glrt_pkg::GLRT_WAIT;
        end
      end
      default: nxt_state = glrt_pkg::GLRT_IDLE;
    endcase
  end
  assign bus_accept = (state_ff == glrt_pkg::GLRT_ACK);

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_ff <= glrt_pkg::GLRT_IDLE;
      end_seen_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      end_seen_ff <= start_any ? 1'b0 : (end_seen_ff | end_rx);
    end
  end

  // ==========================================================
  // Transfer setup captured at start
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mode_ff <= glrt_pkg::GLRT_MODE_STRING;
      tsel_ff <= 2'b00;
      term_en_ff <= 1'b0;
      dma_en_ff <= 1'b0;
    end else if (start_any) begin
      mode_ff <= start_arr ? glrt_pkg::GLRT_MODE_ARRAY : glrt_pkg::GLRT_MODE_STRING;
      tsel_ff <= start_arr ? arr_tsel : str_tsel;
      term_en_ff <= start_arr ? arr_ten : 1'b1;
      dma_en_ff <= start_arr & pwdata[`GLRT_CTL_DMA_EN];
    end
  end

  // Length clamps to the largest buffer; terminator table is writable
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      len_ff <= `GLRT_LEN_RESET;
      terms_ff <= `GLRT_TERMS_RESET;
    end else begin
      if (apb_wr & hit_len) begin
        len_ff <= (pwdata > {15'h0000, `GLRT_LEN_MAX}) ? `GLRT_LEN_MAX : pwdata[16:0];
      end
      if (apb_wr & hit_terms & ~busy) begin
        terms_ff <= pwdata;
      end
    end
  end

  // ==========================================================
  // Status byte and kept-byte count; count cleared and status reloaded with only the not-listener bit at each start
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      status_ff <= 8'h00;
      count_ff <= 17'h0_0000;
    end else if (start_any) begin
      status_ff <= {6'b00_0000, start_nl, 1'b0};
      count_ff <= 17'h0_0000;
    end else begin
      if (keep) begin
        count_ff <= count_inc;
      end
      if (tmo_hit) begin
        status_ff[`GLRT_ST_TMO] <= 1'b1;
      end
      if (take & ~is_array & str_ovf & ~rx_eoi) begin
        status_ff[`GLRT_ST_OVF] <= 1'b1;
      end
      if (take & is_array & end_eot) begin
        status_ff[`GLRT_ST_EOT] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Single holding byte; the talker stalls while it is full
  wire pop_cpu = apb_rd & hit_data & ~dma_en_ff;
  wire pop_dma = dma_en_ff & dma_ack & hold_v_ff;
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      hold_ff <= 8'h00;
      hold_v_ff <= 1'b0;
    end else if (keep) begin
      hold_ff <= rx_byte;
      hold_v_ff <= 1'b1;
    end else if (pop_cpu | pop_dma) begin
      hold_v_ff <= 1'b0;
    end
  end
  assign dma_req = dma_en_ff & hold_v_ff;
  assign dma_data = hold_ff;

  // Timeout counter restarts on every accepted byte
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tmo_cnt_ff <= 32'h0000_0000;
    end else if (!in_wait || take || tmo_hit) begin
      tmo_cnt_ff <= 32'h0000_0000;
    end else begin
      tmo_cnt_ff <= tmo_cnt_ff + 32'h0000_0001;
    end
  end

  // ==========================================================
  // Interrupt status, write one to clear; a new event wins over the clear
  wire [1:0] ev = {keep, done};
  wire [1:0] w1c = (apb_wr & hit_istat) ? pwdata[1:0] : 2'b00;
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      istat_ff <= 2'b00;
      imask_ff <= 2'b00;
    end else begin
      istat_ff <= (istat_ff & ~w1c) | ev;
      if (apb_wr & hit_imask) begin
        imask_ff <= pwdata[1:0];
      end
    end
  end
  assign irq = |(istat_ff & imask_ff);

  // ==========================================================
  // Checks
  property p_eoi_stops;
    @(posedge clk) disable iff (!rst_sync_n)
    (take & rx_eoi) |=> end_seen_ff && (state_ff == glrt_pkg::GLRT_ACK);
  endproperty
  a_eoi_stops: assert property (p_eoi_stops) else $error("EOI byte did not end receive");
  property p_end_idle;
    @(posedge clk) disable iff (!rst_sync_n)
    (bus_accept & end_seen_ff & ~rx_dav) |=> (state_ff == glrt_pkg::GLRT_IDLE);
  endproperty
  a_end_idle: assert property (p_end_idle) else $error("Ended receive did not go idle");
  property p_drop_cr;
    @(posedge clk) disable iff (!rst_sync_n)
    (take & ~is_array & is_cr) |=> $stable(count_ff);
  endproperty
  a_drop_cr: assert property (p_drop_cr) else $error("Carriage return was counted");
  property p_term_stops;
    @(posedge clk) disable iff (!rst_sync_n)
    (take & is_term) |=> end_seen_ff;
  endproperty
  a_term_stops: assert property (p_term_stops) else $error("Terminator did not end receive");
  property p_tmo_flag;
    @(posedge clk) disable iff (!rst_sync_n)
    tmo_hit |=> status_ff[`GLRT_ST_TMO] && state_ff == glrt_pkg::GLRT_IDLE;
  endproperty
  a_tmo_flag: assert property (p_tmo_flag) else $error("Timeout not flagged");
  property p_ovf_flag;
    @(posedge clk) disable iff (!rst_sync_n)
    (take & ~is_array & str_ovf & ~rx_eoi) |=> status_ff[`GLRT_ST_OVF] && $stable(count_ff);
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("Overflow not flagged");
  property p_nl_flag;
    @(posedge clk) disable iff (!rst_sync_n)
    start_nl |=> status_ff[`GLRT_ST_NL] && !busy;
  endproperty
  a_nl_flag: assert property (p_nl_flag) else $error("Not-listener start mishandled");
  property p_count;
    @(posedge clk) disable iff (!rst_sync_n)
    keep |=> count_ff == $past(count_ff) + 17'h0_0001;
  endproperty
  a_count: assert property (p_count) else $error("Kept byte not counted");
  property p_arr_limit;
    @(posedge clk) disable iff (!rst_sync_n)
    (take & is_array & arr_full) |=> end_seen_ff && !status_ff[`GLRT_ST_EOT] || $past(end_eot);
  endproperty
  a_arr_limit: assert property (p_arr_limit) else $error("Array limit not honoured");
  property p_zero_bits;
    @(posedge clk) disable iff (!rst_sync_n)
    (status_ff[7:6] == 2'b00) && !status_ff[4] && !status_ff[0];
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("Unassigned status bit set");
  property p_len_clamp;
    @(posedge clk) disable iff (!rst_sync_n)
    len_ff <= `GLRT_LEN_MAX;
  endproperty
  a_len_clamp: assert property (p_len_clamp) else $error("Length above limit");
endmodule

// ### design/glrt_params.svh
// Offsets, field positions, reset values and timing counts of the listener receive block
`ifndef GLRT_PARAMS_SVH
`define GLRT_PARAMS_SVH
// ==========================================================
// Register byte offsets
`define GLRT_OFS_CTRL 8'h00
`define GLRT_OFS_LEN 8'h04
`define GLRT_OFS_TERMS 8'h08
`define GLRT_OFS_STATUS 8'h0C
`define GLRT_OFS_COUNT 8'h10
`define GLRT_OFS_DATA 8'h14
`define GLRT_OFS_ISTAT 8'h18
`define GLRT_OFS_IMASK 8'h1C
// ==========================================================
// Control register fields
`define GLRT_CTL_START_STR 0
`define GLRT_CTL_START_ARR 1
`define GLRT_CTL_TNUM_LSB 2
`define GLRT_CTL_USE_TNUM 4
`define GLRT_CTL_ACTL_VALID 5
`define GLRT_CTL_DMA_EN 6
`define GLRT_CTL_ACTL_LSB 8
`define GLRT_ACTL_TERM_EN 2
// ==========================================================
// Status byte fields
`define GLRT_ST_NL 1
`define GLRT_ST_OVF 2
`define GLRT_ST_TMO 3
`define GLRT_ST_EOT 5
// Interrupt status fields
`define GLRT_IRQ_DONE 0
`define GLRT_IRQ_DATA 1
// ==========================================================
// Reset values and limits
`define GLRT_TERMS_RESET 32'h3B2C_0D0A
`define GLRT_CR_CHAR 8'h0D
`define GLRT_LEN_MAX 17'h1_0000
`define GLRT_LEN_RESET 17'h0_0050
// ==========================================================
// Timing
`define GLRT_CLK_MHZ 50
`define GLRT_TIMEOUT_US 1000
`define GLRT_TIMEOUT_CYCLES (`GLRT_TIMEOUT_US * `GLRT_CLK_MHZ)
`endif

// ### design/glrt_pkg.sv
// Types shared by the listener receive block
package glrt_pkg;
  // ==========================================================
  // Receive sequencer states, one-hot
  typedef enum logic [2:0] {
    GLRT_IDLE = 3'b001,
    GLRT_WAIT = 3'b010,
    GLRT_ACK = 3'b100
  } glrt_state_type;
  // ==========================================================
  // Receive flavour
  typedef enum logic {
    GLRT_MODE_STRING = 1'b0,
    GLRT_MODE_ARRAY = 1'b1
  } glrt_mode_type;
endpackage

// ### design/dummy_unused_placeholder_never.sv
// Intentionally empty design note file
`timescale 1ns/10ps

// ### dv/glrt_talker_model.sv
// Behavioural talker instrument driving the listener's bus pins
`timescale 1ns/10ps
module glrt_talker_model (
  // Clock
  input wire logic clk,
  // Handshake
  input wire logic bus_accept,
  // Pacing
  input wire logic slow,
  output logic bus_dav,
  output logic bus_eoi,
  output logic [7:0] bus_data
);
  logic [8:0] msg_q[$];
  logic [8:0] cur;
  // ==========================================================
  // Bytes queued by the bench, sent in order
  task automatic send(input logic [7:0] b, input logic e);
    msg_q.push_back({e, b});
  endtask
  // Four-phase talker; released data shows the inverse so stale values never look valid
  initial begin
    bus_dav = 1'b0;
    bus_eoi = 1'b0;
    bus_data = 8'h00;
    forever begin
      @(posedge clk);
      if (msg_q.size() > 0) begin
        cur = msg_q.pop_front();
        bus_data <= cur[7:0];
        bus_eoi <= cur[8];
        @(posedge clk);
        bus_dav <= 1'b1;
        while (bus_accept !== 1'b1) @(posedge clk);
        bus_dav <= 1'b0;
        bus_eoi <= 1'b0;
        bus_data <= ~cur[7:0];
        while (bus_accept !== 1'b0) @(posedge clk);
        // A slow talker leaves gaps between bytes
        if (slow) repeat (7) @(posedge clk);
      end
    end
  end
endmodule

// ### dv/test_gpib_listener_receive_termination.sv
// Self-checking bench of the listener receive block
`timescale 1ns/10ps
`include "glrt_params.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_gpib_listener_receive_termination;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, rd_chk;
  logic [7:0] paddr, dma_data, bus_data;
  logic [31:0] pwdata, prdata, rdata;
  logic bus_dav, bus_eoi, listen_addressed, bus_accept, dma_req, dma_ack, irq, slow_talker;
  logic [15:0] lfsr;
  logic [7:0] b;
  logic [7:0] byte_q[$];
  logic [64:0] reg_q[$];
  logic [64:0] e;
  int error_cnt, cmp_count, cyc;
  // ==========================================================
  // Design and far-side talker
  glrt_listener_rx #(.TMO_CYCLES(50)) glrt_listener_rx_inst (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_dav(bus_dav),
    .bus_eoi(bus_eoi), .bus_data(bus_data), .listen_addressed(listen_addressed),
    .bus_accept(bus_accept), .dma_req(dma_req), .dma_data(dma_data),
    .dma_ack(dma_ack), .irq(irq));
  glrt_talker_model glrt_talker_model_inst (.clk(clk), .bus_accept(bus_accept),
    .slow(slow_talker), .bus_dav(bus_dav), .bus_eoi(bus_eoi), .bus_data(bus_data));
  always #10 clk = ~clk;
  // DMA engine answers a held byte with a one-cycle pulse
  always @(posedge clk) dma_ack <= (dma_req === 1'b1) && !dma_ack;
  // ==========================================================
  // Watcher: takes the oldest note whenever a result appears
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (rd_chk) begin
        e = reg_q.pop_front();
        `CHK({pslverr, prdata & e[63:32]}, {e[64], e[31:0]})
      end else if (paddr == `GLRT_OFS_DATA && prdata[8] === 1'b1 && dma_req === 1'b0) begin
        `CHK(prdata[7:0], byte_q.pop_front())
      end
    end
    if (dma_req === 1'b1 && dma_ack) `CHK(dma_data, byte_q.pop_front())
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      print_verdict();
    end
  end
  // ==========================================================
  // Tasks
  task automatic print_verdict();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // One APB transfer; read data taken at the edge that sees pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Wait states are the slave's business; only the hang guard ends this wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    rd_chk <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m,
                    input logic er);
    reg_q.push_back({er, m, v});
    rd_chk <= 1'b1;
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic tx(input logic [7:0] d, input logic eoi, input logic keep);
    glrt_talker_model_inst.send(d, eoi);
    if (keep) byte_q.push_back(d);
  endtask
  // Start, drain while busy, then check count and status
  task automatic run(input logic [31:0] ctl, input logic [31:0] cnt, input logic [31:0] st);
    apb(1'b1, `GLRT_OFS_CTRL, ctl);
    do begin
      apb(1'b0, `GLRT_OFS_DATA, 32'h0000_0000);
      apb(1'b0, `GLRT_OFS_CTRL, 32'h0000_0000);
    end while (rdata[0] !== 1'b0);
    apb(1'b0, `GLRT_OFS_DATA, 32'h0000_0000);
    rd(`GLRT_OFS_COUNT, cnt, 32'h0001_FFFF, 1'b0);
    rd(`GLRT_OFS_STATUS, st, 32'h0000_00FF, 1'b0);
    `CHK(byte_q.size(), 0)
  endtask
  task automatic irq_is(input logic x);
    repeat (2) @(posedge clk);
    `CHK(irq, x)
  endtask
  // Random source for payload bytes
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // ==========================================================
  // Main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {psel, penable, pwrite, rd_chk, slow_talker} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    listen_addressed = 1'b0;
    lfsr = 16'h0010;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`GLRT_OFS_LEN, 32'h0000_0050, 32'h0001_FFFF, 1'b0);
    rd(`GLRT_OFS_TERMS, 32'h3B2C_0D0A, 32'hFFFF_FFFF, 1'b0);
    rd(8'h20, 32'h0000_0000, 32'h0000_0000, 1'b1);
    // Not addressed; done event masked, then unmasked and cleared
    run(32'h0000_0001, 32'h0000_0000, 32'h0000_0002);
    irq_is(1'b0);
    apb(1'b1, `GLRT_OFS_IMASK, 32'h0000_0001);
    irq_is(1'b1);
    apb(1'b1, `GLRT_OFS_ISTAT, 32'h0000_0003);
    irq_is(1'b0);
    listen_addressed <= 1'b1;
    // Pin passes two synchroniser stages before a start may see it
    repeat (3) @(posedge clk);
    // Default terminator, CR dropped
    tx(8'h41, 1'b0, 1'b1);
    tx(8'h0D, 1'b0, 1'b0);
    tx(8'h42, 1'b0, 1'b1);
    tx(8'h0A, 1'b0, 1'b0);
    run(32'h0000_0001, 32'h0000_0002, 32'h0000_0000);
    // Kept-byte event alone raises the interrupt once done is cleared
    apb(1'b1, `GLRT_OFS_IMASK, 32'h0000_0002);
    apb(1'b1, `GLRT_OFS_ISTAT, 32'h0000_0001);
    irq_is(1'b1);
    apb(1'b1, `GLRT_OFS_ISTAT, 32'h0000_0002);
    irq_is(1'b0);
    // Reprogrammed terminator 3, random payload, slow talker
    apb(1'b1, `GLRT_OFS_TERMS, 32'h7E2C_0D0A);
    rd(`GLRT_OFS_TERMS, 32'h7E2C_0D0A, 32'hFFFF_FFFF, 1'b0);
    slow_talker <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      b = lfsr[7:0];
      if (b == 8'h0D || b == 8'h7E) b = 8'h55;
      tx(b, 1'b0, 1'b1);
    end
    tx(8'h7E, 1'b0, 1'b0);
    run(32'h0000_001D, 32'h0000_0004, 32'h0000_0000);
    slow_talker <= 1'b0;
    // EOI on an ordinary byte
    tx(8'h51, 1'b0, 1'b1);
    tx(8'h52, 1'b1, 1'b1);
    run(32'h0000_0001, 32'h0000_0002, 32'h0000_0000);
    // One byte beyond a three-byte buffer
    apb(1'b1, `GLRT_OFS_LEN, 32'h0000_0003);
    for (int i = 0; i < 4; i++) tx(8'h30 + 8'(i), 1'b0, i < 3);
    run(32'h0000_0001, 32'h0000_0003, 32'h0000_0004);
    apb(1'b1, `GLRT_OFS_LEN, 32'h0001_FFFF);
    rd(`GLRT_OFS_LEN, 32'h0001_0000, 32'h0001_FFFF, 1'b0);
    // Silent talker
    run(32'h0000_0001, 32'h0000_0000, 32'h0000_0008);
    // Array by DMA, every terminator number, ignored high bits set
    apb(1'b1, `GLRT_OFS_TERMS, 32'h3B2C_0D0A);
    apb(1'b1, `GLRT_OFS_LEN, 32'h0000_0050);
    for (int i = 0; i < 4; i++) begin
      tx(8'h41, 1'b0, 1'b1);
      tx(8'(32'h3B2C_0D0A >> (8 * i)), 1'b0, 1'b1);
      run({16'h0000, 8'hFC | 8'(i), 8'h62}, 32'h0000_0002, 32'h0000_0020);
    end
    // Array without control byte: LF is data, EOI ends
    tx(8'h0A, 1'b0, 1'b1);
    tx(8'h42, 1'b1, 1'b1);
    run(32'h0000_0002, 32'h0000_0002, 32'h0000_0020);
    // Array ends on byte limit
    apb(1'b1, `GLRT_OFS_LEN, 32'h0000_0002);
    tx(8'h01, 1'b0, 1'b1);
    tx(8'h02, 1'b0, 1'b1);
    run(32'h0000_0002, 32'h0000_0002, 32'h0000_0000);
    print_verdict();
  end
endmodule
